// [core/eil_top.sv]
// External interrupt latch: pin sensing, request latch and registers.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
//
// What this block does
// - A low on the interrupt pin sets the latch as the sensitivity allows.
// - Fetching this interrupt's vector makes an acknowledge strobe.
// - Writing one to the acknowledge bit clears the latch.
// - Every reset leaves no request pending.
// - In edge mode only falling edges count and an acknowledge clears.
// - In level mode the request ends after an acknowledge and a high pin.
// - Reset clears the latch and the sensitivity select bit.
// - With the mask bit set no request goes to the CPU; latch is kept.
// - The pending flag shows the latch regardless of the mask bit.
// - A falling edge after an acknowledge latches a fresh request.
// - An unmasked request is served from the vector at FFFA and FFFB.
// - In break state with clear-enable low, an acknowledge write does not clear the latch.
// - In break state with clear-enable high, an acknowledge clears.
// - The acknowledge bit is write-only, reads zero and resets to zero.
// - The mask bit is read/write, one disables, reset clears it.
// - The pin level, sampled one clock earlier, is offered to the branch-on-pin logic.
module eil_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ext_int_pin_n,
  input wire logic cpu_fetch_valid,
  input wire logic [15:0] cpu_fetch_addr,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic cpu_int_request,
  output logic int_ack_strobe,
  output logic branch_pin_high,
  output logic branch_pin_low,
  output logic irq,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [eil_pkg::EIL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [eil_pkg::EIL_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import eil_pkg::*;

  ////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    eil_latch_st_t latch_st;
    logic armed;
    logic mode;
    logic mask;
    logic pin_high;
    logic pin_low;
    logic [EIL_EV_W-1:0] ev_status;
    logic [EIL_EV_W-1:0] ev_mask;
    logic cpu_req;
    logic ack_strobe;
    logic irq;
  } eil_core_t;

  eil_core_t st_reg;
  eil_core_t st_next;

  logic wr_en;
  logic [EIL_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [EIL_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;

  logic pin_low;
  logic fall;
  logic isc_wr;
  logic sw_ack_wr;
  logic sw_ack;
  logic vec_ack;
  logic ack_any;
  logic pending;
  logic pend_next;

  ////////////////////////////////////////////////////////////////////////

  // Register access goes through the bus front end.
  eil_axil_slave u_bus (
    .mclk(mclk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////

  // Edge detect against the previous sample; pin_high doubles as that
  // sample. The armed bit waits one real sample after reset, so a pin
  // held low through reset is not mistaken for a fresh falling edge.
  assign pin_low = !ext_int_pin_n;
  assign fall = st_reg.armed && st_reg.pin_high && pin_low;
  assign pending = (st_reg.latch_st != EIL_ST_IDLE);

  // Software acknowledge; break state may protect the latch.
  assign isc_wr = wr_en && (wr_addr == EIL_OFF_ISC) && wr_strb[0];
  assign sw_ack_wr = isc_wr && wr_data[EIL_BIT_ACK];
  assign sw_ack = sw_ack_wr && (!break_state || break_clear_enable);
  // Fetch of the high vector byte is the hardware acknowledge.
  assign vec_ack = cpu_fetch_valid && st_reg.cpu_req
                   && (cpu_fetch_addr == EIL_VEC_HI_ADDR);
  assign ack_any = sw_ack || vec_ack;

  ////////////////////////////////////////////////////////////////////////

  // Next-state logic for the latch, control bits and event flags.
  always_comb begin
    st_next = st_reg;
    // Latch state machine.
    case (st_reg.latch_st)
      EIL_ST_IDLE: begin
        // A level already low latches at once in level mode.
        if (fall || (st_reg.mode && pin_low)) begin
          st_next.latch_st = EIL_ST_PEND;
        end
      end
      EIL_ST_PEND: begin
        if (ack_any && !fall) begin
          if (st_reg.mode && pin_low) begin
            st_next.latch_st = EIL_ST_WAIT_HIGH;
          end else begin
            st_next.latch_st = EIL_ST_IDLE;
          end
        end
      end
      EIL_ST_WAIT_HIGH: begin
        // Edge mode clears at once, so leaving level mode ends the wait.
        if (ext_int_pin_n || !st_reg.mode) begin
          st_next.latch_st = EIL_ST_IDLE;
        end
      end
      default: begin
        st_next.latch_st = EIL_ST_IDLE;
      end
    endcase
    // A fresh edge always wins over a same-cycle acknowledge.
    if (fall) begin
      st_next.latch_st = EIL_ST_PEND;
    end
    // Control bits; the acknowledge bit is never stored.
    if (isc_wr) begin
      st_next.mode = wr_data[EIL_BIT_MODE];
      st_next.mask = wr_data[EIL_BIT_MASK];
    end
    if (wr_en && (wr_addr == EIL_OFF_EVMSK) && wr_strb[0]) begin
      st_next.ev_mask = wr_data[EIL_EV_W-1:0];
    end
    // Sticky events: write one clears, a new event wins over the clear.
    st_next.ev_status = st_reg.ev_status;
    if (wr_en && (wr_addr == EIL_OFF_EVST) && wr_strb[0]) begin
      st_next.ev_status = st_reg.ev_status & ~wr_data[EIL_EV_W-1:0];
    end
    if (!pending && (st_next.latch_st != EIL_ST_IDLE)) begin
      st_next.ev_status[EIL_EV_LATCH] = 1'b1;
    end
    if (ack_any) begin
      st_next.ev_status[EIL_EV_ACK] = 1'b1;
    end
    // Outputs are computed from next state so they leave flops directly.
    st_next.cpu_req = (st_next.latch_st != EIL_ST_IDLE)
                      && !st_next.mask;
    st_next.ack_strobe = vec_ack;
    st_next.armed = 1'b1;
    st_next.pin_high = ext_int_pin_n;
    st_next.pin_low = pin_low;
    st_next.irq = |(st_next.ev_status & st_next.ev_mask);
  end

  assign pend_next = (st_next.latch_st != EIL_ST_IDLE);

  // State register; reset empties the latch and clears mode and mask.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg.latch_st <= EIL_ST_IDLE;
      st_reg.armed <= 1'b0;
      st_reg.mode <= EIL_MODE_RST;
      st_reg.mask <= EIL_MASK_RST;
      st_reg.pin_high <= 1'b1;
      st_reg.pin_low <= 1'b0;
      st_reg.ev_status <= '0;
      st_reg.ev_mask <= EIL_EVMSK_RST;
      st_reg.cpu_req <= 1'b0;
      st_reg.ack_strobe <= 1'b0;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // Read data; unused bits and the acknowledge bit read as zero.
  always_comb begin
    rd_data = 32'h00000000;
    case (rd_addr)
      EIL_OFF_ISC: begin
        rd_data[EIL_BIT_MODE] = st_reg.mode;
        rd_data[EIL_BIT_MASK] = st_reg.mask;
        rd_data[EIL_BIT_ACK] = 1'b0;
        rd_data[EIL_BIT_PEND] = pending;
      end
      EIL_OFF_EVST: begin
        rd_data[EIL_EV_W-1:0] = st_reg.ev_status;
      end
      EIL_OFF_EVMSK: begin
        rd_data[EIL_EV_W-1:0] = st_reg.ev_mask;
      end
      EIL_OFF_PIN: begin
        rd_data[EIL_PIN_LVL] = st_reg.pin_high;
        rd_data[EIL_PIN_REQ] = st_reg.cpu_req;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  // Top outputs, each a flop of the state register.
  assign cpu_int_request = st_reg.cpu_req;
  assign int_ack_strobe = st_reg.ack_strobe;
  assign branch_pin_high = st_reg.pin_high;
  assign branch_pin_low = st_reg.pin_low;
  assign irq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////

  // Nothing is pending in the first cycle after reset is released.
  a_reset_clears_latch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> (!pending && !st_reg.mode && !st_reg.mask
                      && !cpu_int_request))
    else $error("Latch or control bits set right after reset.");

  // A high sample followed by a low sample latches a request.
  a_fall_sets_latch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st_reg.armed && branch_pin_high && !ext_int_pin_n) |=> pending)
    else $error("Falling edge did not latch a request.");

  // A falling edge right after an acknowledge write relatches.
  a_edge_after_ack: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sw_ack && !st_reg.mode && !fall) ##1 fall |=> pending)
    else $error("Edge after acknowledge was lost.");

  // In edge mode an acknowledge clears at once, whatever the pin.
  a_edge_ack_clears: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!st_reg.mode && pending && sw_ack && !fall) |=> !pending)
    else $error("Edge mode acknowledge did not clear the latch.");

  // In level mode the request holds until acknowledged.
  a_level_needs_ack: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st_reg.mode && st_reg.latch_st == EIL_ST_PEND && !ack_any)
    |=> pending)
    else $error("Level request dropped without acknowledge.");

  // In level mode the request holds while the pin stays low.
  a_level_holds_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st_reg.mode && pending && !ext_int_pin_n) |=> pending)
    else $error("Level request dropped while pin low.");

  // Acknowledged and pin high: the request is gone next cycle.
  a_level_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st_reg.latch_st == EIL_ST_WAIT_HIGH && ext_int_pin_n)
    |=> !pending)
    else $error("Level request stayed after pin returned high.");

  // A protected break state keeps the latch through acknowledge writes.
  a_break_blocks_ack: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sw_ack_wr && break_state && !break_clear_enable
     && st_reg.latch_st == EIL_ST_PEND && !vec_ack) |=> pending)
    else $error("Acknowledge took effect in protected break state.");

  // An enabled clear in break state leaves the latch cleared.
  a_break_ack_clears: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sw_ack_wr && break_state && break_clear_enable
     && st_reg.latch_st == EIL_ST_PEND && ext_int_pin_n && !fall)
    |=> !pending)
    else $error("Enabled break-state acknowledge did not clear.");

  // The CPU sees the request exactly when pending and unmasked.
  a_mask_gates_req: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cpu_int_request == (pending && !st_reg.mask))
    else $error("CPU request does not follow latch and mask.");

  // Fetching the vector while requested gives a one-cycle strobe.
  a_vector_ack_pulse: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (cpu_fetch_valid && cpu_fetch_addr == EIL_VEC_HI_ADDR
     && cpu_int_request) |=> int_ack_strobe ##1 !int_ack_strobe
     || $past(vec_ack, 1))
    else $error("Vector fetch strobe missing or stretched.");

  // The acknowledge bit always reads back as zero.
  a_ack_reads_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_rdata[EIL_BIT_ACK])
    else $error("Acknowledge bit read back as one.");

  // Branch level outputs follow the pin one clock later.
  a_pin_level: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> (branch_pin_high == $past(ext_int_pin_n)
                      && branch_pin_low == !branch_pin_high))
    else $error("Branch pin level does not follow the pin.");

  // Pending readback does not depend on the mask bit.
  a_flag_no_mask: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st_next.mask && pend_next) |=> (pending && !cpu_int_request))
    else $error("Masked request lost from the pending flag.");

endmodule

// [common/eil_pkg.sv]
// Shared constants and state types of the external interrupt latch.
package eil_pkg;

  // Register bus geometry.
  localparam int EIL_ADDR_W = 5;
  localparam int EIL_DATA_W = 32;

  // Register byte offsets.
  localparam logic [4:0] EIL_OFF_ISC = 5'h00;
  localparam logic [4:0] EIL_OFF_EVST = 5'h04;
  localparam logic [4:0] EIL_OFF_EVMSK = 5'h08;
  localparam logic [4:0] EIL_OFF_PIN = 5'h0C;

  // Field positions of ext_int_status_control.
  localparam int EIL_BIT_MODE = 0;
  localparam int EIL_BIT_MASK = 1;
  localparam int EIL_BIT_ACK = 2;
  localparam int EIL_BIT_PEND = 3;

  // Event status and event mask layout.
  localparam int EIL_EV_W = 2;
  localparam int EIL_EV_LATCH = 0;
  localparam int EIL_EV_ACK = 1;

  // Pin state register layout.
  localparam int EIL_PIN_LVL = 0;
  localparam int EIL_PIN_REQ = 1;

  // Vector fetch addresses of this interrupt.
  localparam logic [15:0] EIL_VEC_HI_ADDR = 16'hFFFA;
  localparam logic [15:0] EIL_VEC_LO_ADDR = 16'hFFFB;

  // Bus responses.
  localparam logic [1:0] EIL_RESP_OKAY = 2'h0;
  localparam logic [1:0] EIL_RESP_SLVERR = 2'h2;

  // Request latch states.
  typedef enum logic [1:0] {
    EIL_ST_IDLE,
    EIL_ST_PEND,
    EIL_ST_WAIT_HIGH
  } eil_latch_st_t;

  // Values after reset.
  localparam logic EIL_MODE_RST = 1'b0;
  localparam logic EIL_MASK_RST = 1'b0;
  localparam logic [EIL_EV_W-1:0] EIL_EVMSK_RST = 2'h0;

endpackage

// [core/eil_axil_slave.sv]
// AXI4-Lite slave front end for the external interrupt latch registers.
`timescale 1ns/1ps
module eil_axil_slave (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [eil_pkg::EIL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [eil_pkg::EIL_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic wr_en,
  output logic [eil_pkg::EIL_ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [eil_pkg::EIL_ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data
);
  import eil_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [EIL_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_have;
    logic [EIL_ADDR_W-1:0] araddr;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wr_en;
  } eil_axil_t;

  eil_axil_t q_reg;
  eil_axil_t q_next;

  // Aligned words below 0x10 are mapped; anything else gets SLVERR.
  function automatic logic eil_hit(input logic [EIL_ADDR_W-1:0] a);
    eil_hit = (a[1:0] == 2'h0) && (a[4] == 1'b0);
  endfunction

  // Address and data are collected in either order; one write and one
  // read are handled at a time, so readies drop while a response waits.
  always_comb begin
    q_next = q_reg;
    q_next.wr_en = 1'b0;
    if (s_axi_awvalid && q_reg.awready) begin
      q_next.aw_have = 1'b1;
      q_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_reg.wready) begin
      q_next.w_have = 1'b1;
      q_next.wdata = s_axi_wdata;
      q_next.wstrb = s_axi_wstrb;
    end
    if (q_reg.bvalid && s_axi_bready) begin
      q_next.bvalid = 1'b0;
    end
    if (q_reg.aw_have && q_reg.w_have && !q_reg.bvalid) begin
      q_next.bvalid = 1'b1;
      q_next.bresp = eil_hit(q_reg.awaddr) ? EIL_RESP_OKAY : EIL_RESP_SLVERR;
      q_next.wr_en = eil_hit(q_reg.awaddr);
      q_next.aw_have = 1'b0;
      q_next.w_have = 1'b0;
    end
    q_next.awready = !q_next.aw_have && !q_next.bvalid;
    q_next.wready = !q_next.w_have && !q_next.bvalid;
    if (s_axi_arvalid && q_reg.arready) begin
      q_next.ar_have = 1'b1;
      q_next.araddr = s_axi_araddr;
    end
    if (q_reg.rvalid && s_axi_rready) begin
      q_next.rvalid = 1'b0;
    end
    if (q_reg.ar_have && !q_reg.rvalid) begin
      q_next.rvalid = 1'b1;
      q_next.rdata = eil_hit(q_reg.araddr) ? rd_data : 32'h00000000;
      q_next.rresp = eil_hit(q_reg.araddr) ? EIL_RESP_OKAY : EIL_RESP_SLVERR;
      q_next.ar_have = 1'b0;
    end
    q_next.arready = !q_next.ar_have && !q_next.rvalid;
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Bus and register-side outputs, all taken from flops.
  assign s_axi_awready = q_reg.awready;
  assign s_axi_wready = q_reg.wready;
  assign s_axi_bvalid = q_reg.bvalid;
  assign s_axi_bresp = q_reg.bresp;
  assign s_axi_arready = q_reg.arready;
  assign s_axi_rvalid = q_reg.rvalid;
  assign s_axi_rdata = q_reg.rdata;
  assign s_axi_rresp = q_reg.rresp;
  assign wr_en = q_reg.wr_en;
  assign wr_addr = q_reg.awaddr;
  assign wr_data = q_reg.wdata;
  assign wr_strb = q_reg.wstrb;
  assign rd_addr = q_reg.araddr;

endmodule

// [tb/eil_pin_source.sv]
// Behavioural external source that drives the interrupt pin.
`timescale 1ns/1ps
module eil_pin_source (
  input wire logic mclk,
  input wire logic pull_low,
  output logic ext_int_pin_n
);
  // A released pin is held high by the internal pull-up.
  initial ext_int_pin_n = 1'b1;
  // The source moves the pin just after an edge, so the latch never races it.
  always @(posedge mclk) begin
    ext_int_pin_n <= ~pull_low;
  end
endmodule

// [tb/eil_top_tb.sv]
// Self-checking bench for the external interrupt latch.
`timescale 1ns/1ps
module eil_top_tb;
  import eil_pkg::*;
  typedef struct {
    logic [4:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic [1:0] resp;
  } eil_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic pull_low = 1'b0;
  logic pin_n;
  logic fetch_v = 1'b0;
  logic [15:0] fetch_a = 16'h0000;
  logic brk = 1'b0;
  logic bce = 1'b0;
  logic req, ack_stb, bph, bpl, irq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, resp;
  int failures = 0;
  int tests_run = 0;
  eil_row_t rows [6] = '{
    '{EIL_OFF_ISC, 32'h0000_0003, 32'h0000_0003, EIL_RESP_OKAY},
    '{EIL_OFF_ISC, 32'h0000_0006, 32'h0000_0002, EIL_RESP_OKAY},
    '{EIL_OFF_ISC, 32'h0000_0000, 32'h0000_0000, EIL_RESP_OKAY},
    '{EIL_OFF_EVMSK, 32'h0000_0003, 32'h0000_0003, EIL_RESP_OKAY},
    '{5'h10, 32'h0000_00FF, 32'h0000_0000, EIL_RESP_SLVERR},
    '{5'h02, 32'h0000_00FF, 32'h0000_0000, EIL_RESP_SLVERR}
  };

  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;

  eil_pin_source SRC (.mclk(mclk), .pull_low(pull_low), .ext_int_pin_n(pin_n));

  eil_top DUT (
    .mclk(mclk), .rst_n(rst_n), .ext_int_pin_n(pin_n),
    .cpu_fetch_valid(fetch_v), .cpu_fetch_addr(fetch_a),
    .break_state(brk), .break_clear_enable(bce),
    .cpu_int_request(req), .int_ack_strobe(ack_stb),
    .branch_pin_high(bph), .branch_pin_low(bpl), .irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Every compare funnels through here so the counts stay honest.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Each task starts on a fresh edge so no strobe is driven twice at once.
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [4:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    axi_write(a, d);
    check("bresp", {30'h0, resp}, {30'h0, EIL_RESP_OKAY});
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a,
                        input logic [31:0] exp);
    axi_read(a);
    check(what, rd, exp);
  endtask

  // Bounded wait; the pin path takes a few edges through the source.
  task automatic wait_req(input logic v);
    for (int i = 0; i < 8 && req !== v; i++) @(posedge mclk);
    check("cpu_int_request", {31'h0, req}, {31'h0, v});
  endtask

  // Reset is synchronous, so it is held across sixteen edges.
  task automatic do_reset();
    rst_n <= 1'b0;
    cyc(16);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A hung handshake ends here rather than running forever.
  initial begin
    cyc(6000);
    failures++;
    give_verdict();
  end

  // Main sequence: reset values, register table, then latch behaviour.
  initial begin
    do_reset();
    check("req after reset", {31'h0, req}, 32'h0);
    rd_chk("isc reset", EIL_OFF_ISC, 32'h0);
    rd_chk("evmsk reset", EIL_OFF_EVMSK, 32'h0);
    rd_chk("pin reset", EIL_OFF_PIN, 32'h1);
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].d);
      check("row bresp", {30'h0, resp}, {30'h0, rows[i].resp});
      axi_read(rows[i].a);
      check("row rdata", rd, rows[i].exp);
      check("row rresp", {30'h0, resp}, {30'h0, rows[i].resp});
    end
    // Edge mode: a fall latches, the vector fetch clears it.
    pull_low <= 1'b1;
    wait_req(1'b1);
    cyc(2);
    check("irq raised", {31'h0, irq}, 32'h1);
    check("pin low", {31'h0, bpl}, 32'h1);
    check("pin high flag", {31'h0, bph}, 32'h0);
    rd_chk("isc pending", EIL_OFF_ISC, 32'h8);
    fetch_v <= 1'b1;
    fetch_a <= EIL_VEC_HI_ADDR;
    @(posedge mclk);
    fetch_v <= 1'b0;
    for (int i = 0; i < 4 && ack_stb !== 1'b1; i++) @(posedge mclk);
    check("ack strobe", {31'h0, ack_stb}, 32'h1);
    check("req at ack", {31'h0, req}, 32'h0);
    cyc(3);
    check("req pin low", {31'h0, req}, 32'h0);
    wr(EIL_OFF_EVST, 32'h3);
    cyc(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(EIL_OFF_EVMSK, 32'h0);
    // Software acknowledge, then a later fall latches again.
    pull_low <= 1'b0;
    cyc(3);
    pull_low <= 1'b1;
    wait_req(1'b1);
    rd_chk("evst", EIL_OFF_EVST, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(EIL_OFF_ISC, 32'h4);
    rd_chk("isc sw ack", EIL_OFF_ISC, 32'h0);
    pull_low <= 1'b0;
    cyc(3);
    pull_low <= 1'b1;
    wait_req(1'b1);
    // The mask hides the request but the latch keeps it.
    wr(EIL_OFF_ISC, 32'h2);
    wait_req(1'b0);
    rd_chk("isc masked", EIL_OFF_ISC, 32'hA);
    wr(EIL_OFF_ISC, 32'h0);
    wait_req(1'b1);
    wr(EIL_OFF_ISC, 32'h4);
    wait_req(1'b0);
    // Level mode: both the acknowledge and a high pin are needed.
    wr(EIL_OFF_ISC, 32'h1);
    wait_req(1'b1);
    wr(EIL_OFF_ISC, 32'h5);
    cyc(2);
    rd_chk("isc level", EIL_OFF_ISC, 32'h9);
    pull_low <= 1'b0;
    wait_req(1'b0);
    pull_low <= 1'b1;
    wait_req(1'b1);
    pull_low <= 1'b0;
    cyc(4);
    check("req pin high", {31'h0, req}, 32'h1);
    wr(EIL_OFF_ISC, 32'h5);
    wait_req(1'b0);
    // Break state guards the latch unless clearing is enabled.
    brk <= 1'b1;
    pull_low <= 1'b1;
    wait_req(1'b1);
    pull_low <= 1'b0;
    cyc(4);
    wr(EIL_OFF_ISC, 32'h5);
    cyc(3);
    check("req break", {31'h0, req}, 32'h1);
    bce <= 1'b1;
    wr(EIL_OFF_ISC, 32'h5);
    wait_req(1'b0);
    brk <= 1'b0;
    bce <= 1'b0;
    cyc(3);
    check("req after break", {31'h0, req}, 32'h0);
    // A reset while the pin is held low still drops the request.
    pull_low <= 1'b1;
    wait_req(1'b1);
    do_reset();
    check("req reset low", {31'h0, req}, 32'h0);
    cyc(3);
    check("req stays low", {31'h0, req}, 32'h0);
    axi_read(EIL_OFF_ISC);
    check("mode reset", {31'h0, rd[EIL_BIT_MODE]}, 32'h0);
    pull_low <= 1'b0;
    give_verdict();
  end
endmodule
